// ===== hdl/conv_if.sv
// Link between the channel sequencer and the converter timing engine
interface conv_if;
   import sar_seq_pkg::*;

   logic   start;       // Begin a sample window, same cycle as done allowed
   stime_t len;         // Sample time of the channel being started
   logic   halt;        // Power-down: abandon work and stop the clock
   logic   done;        // Last core cycle of a conversion
   logic   sampling;    // Sample window in progress
   logic   converting;  // Conversion in progress
   logic   conv_clk;    // Converter clock

   modport ctrl  (output start, len, halt,
                  input  done, sampling, converting, conv_clk);
   modport timer (input  start, len, halt,
                  output done, sampling, converting, conv_clk);
endinterface

// ===== hdl/sar_adc_channel_sequencer.sv
// Eight-input channel sequencer with result buffers and range check
//
// Behaviour
// (R1) Results are twelve bits wide
// (R2) Converter clock capped; conversion takes eighteen clocks
// (R3) Sample window length is software programmable
// (R4) Input chosen from eight pins by sequencer
// (R5) Scan steps enabled channels with no gap
// (R6) Hardware scan or firmware-selected channel
// (R7) Separate result buffer for each channel
// (R8) Each channel uses its own sample time
// (R9) Low and high limits raise out-of-range flag
// (R10) Range check acts on each result immediately
// (R11) Converter halts entirely during deep sleep
// (R12) Strictly outside limits; flag stays until cleared
// (R13) Buffer holds latest result of its channel

// Widths are needed by the port list, so the constants come first
`include "sar_seq_map.svh"

module sar_adc_channel_sequencer
   import sar_seq_pkg::*;
(
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   input  wire logic                      deep_sleep,
   input  wire logic                      scan_mode,
   input  wire logic                      scan_run,
   input  wire logic [7:0]                chan_enable,
   input  wire logic                      fw_start,
   input  wire chan_t                     fw_chan,
   input  wire logic [7:0][`SAR_STIME_W-1:0] sample_time,
   input  wire sample_t                   range_low,
   input  wire sample_t                   range_high,
   input  wire logic                      irq_clr,
   input  wire logic [7:0]                ready_clr,
   input  wire sample_t                   sar_data_in,
   output logic                           conv_clk,
   output chan_t                          mux_sel,
   output logic                           sample_hold,
   output logic                           convert,
   output logic                           busy,
   output logic [7:0][`SAR_DATA_W-1:0]    result,
   output logic [7:0]                     result_ready,
   output logic                           range_irq,
   output logic                           scan_done
);

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      sample_t                    sy1;    // Pin sampler, first stage
      sample_t                    sy2;    // Pin sampler, second stage
      sample_t                    sy3;    // Pin sampler, third stage
      sample_t                    filt;   // Settled converter output
      chan_t                      chan;   // Channel on the multiplexer
      logic [7:0][`SAR_DATA_W-1:0] res;   // Per-channel result buffers
      logic [7:0]                 ready;  // New result per channel
      logic                       irq;    // Out-of-range flag
      logic                       sdone;  // Scan pass finished pulse
   } seq_s;

   seq_s  s;       // Registered state
   seq_s  next_s;  // Next state
   logic  free;    // Engine can take a start this cycle
   logic  oor;     // Result now finishing is out of range
   chan_t nxt;     // Next enabled channel in scan order

   conv_if cif ();

   ////////////////////////////////////////////////////////////////////////
   // Timing engine
   sar_conv_timer u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .cif      (cif.timer)
   );

   ////////////////////////////////////////////////////////////////////////
   // First enabled channel at or after base, wrapping round
   function automatic chan_t pick(chan_t base, logic [7:0] en);
      chan_t c;
      pick = base;
      for (int k = 7; k >= 0; k--) begin
         c = base + chan_t'(k);
         if (en[c]) begin
            pick = c;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next state: sampling of pins, channel choice, results and flags
   always_comb begin
      next_s = s;
      // Three-stage pin sampler; a bit changes once stages two and
      // three agree, so a bit caught mid-transition is not taken
      next_s.sy1  = sar_data_in;
      next_s.sy2  = s.sy1;
      next_s.sy3  = s.sy2;
      next_s.filt = (s.sy2 & s.sy3) | (s.filt & (s.sy2 ^ s.sy3));
      next_s.sdone = 1'b0;
      free = (!cif.sampling && !cif.converting) || cif.done;
      nxt  = pick(cif.done ? chan_t'(s.chan + 1'b1) : '0, chan_enable);
      // Strict comparison against both limits, per result [R9] [R10]
      oor  = cif.done &&
             ((s.filt < range_low) || (s.filt > range_high));  // [R12]
      cif.start = 1'b0;
      // Clears first, so a set in the same cycle wins
      next_s.ready = s.ready & ~ready_clr;
      next_s.irq   = (s.irq & ~irq_clr) | oor;  // [R12]
      // Store full-width result in the channel's own buffer [R1] [R7]
      if (cif.done) begin
         next_s.res[s.chan]   = s.filt;  // [R13]
         next_s.ready[s.chan] = 1'b1;
      end
      if (scan_mode) begin
         // Hardware scan: chain straight into the next channel [R5]
         if (scan_run && (|chan_enable) && free && !deep_sleep) begin
            cif.start   = 1'b1;
            next_s.chan = nxt;  // [R4]
            // Wrapping back marks the end of one pass
            if (cif.done && nxt <= s.chan) begin
               next_s.sdone = 1'b1;
            end
         end
      end else if (fw_start && free && !deep_sleep) begin
         // Firmware picks each channel itself [R6]
         cif.start   = 1'b1;
         next_s.chan = fw_chan;
      end
      // Window length follows the channel being started [R8]
      cif.len  = sample_time[next_s.chan];
      cif.halt = deep_sleep;  // [R11]
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s       <= '0;
         s.chan  <= `SAR_RST_CHAN;
         s.irq   <= `SAR_RST_FLAG;
         s.sdone <= `SAR_RST_FLAG;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign conv_clk     = cif.conv_clk;
   assign mux_sel      = s.chan;
   assign sample_hold  = cif.sampling;
   assign convert      = cif.converting;
   assign busy         = cif.sampling | cif.converting;
   assign result       = s.res;
   assign result_ready = s.ready;
   assign range_irq    = s.irq;
   assign scan_done    = s.sdone;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_zero_dead: assert property (  // [R5]
      @(posedge core_clk) disable iff (!rst_n)
      (cif.done && scan_mode && scan_run && (|chan_enable) &&
       !deep_sleep) |=> sample_hold && $changed(busy) == 1'b0)
      else $error("gap between scanned channels");

   a_mux_steady: assert property (  // [R4]
      @(posedge core_clk) disable iff (!rst_n)
      (busy && !cif.done) |=> $stable(mux_sel))
      else $error("channel changed mid-conversion");

   a_result_store: assert property (  // [R7] [R13]
      @(posedge core_clk) disable iff (!rst_n)
      cif.done |=> result[$past(mux_sel)] == $past(s.filt) &&
                   result_ready[$past(mux_sel)])
      else $error("result not stored for its channel");

   a_range_flag: assert property (  // [R9] [R10]
      @(posedge core_clk) disable iff (!rst_n)
      (cif.done && (s.filt < range_low || s.filt > range_high))
      |=> range_irq)
      else $error("out-of-range result not flagged");

   a_flag_quiet: assert property (  // [R12]
      @(posedge core_clk) disable iff (!rst_n)
      (!range_irq && !oor) |=> !range_irq)
      else $error("flag set without out-of-range result");

   a_flag_hold: assert property (  // [R12]
      @(posedge core_clk) disable iff (!rst_n)
      (range_irq && !irq_clr) |=> range_irq)
      else $error("flag dropped without clear");

   a_fw_select: assert property (  // [R6]
      @(posedge core_clk) disable iff (!rst_n)
      (!scan_mode && fw_start && !busy && !deep_sleep)
      |=> sample_hold && mux_sel == $past(fw_chan))
      else $error("firmware channel not selected");

   a_fw_single: assert property (  // [R6]
      @(posedge core_clk) disable iff (!rst_n)
      (!scan_mode && cif.done && !fw_start) |=> !busy)
      else $error("firmware mode kept converting");

   a_sleep_idle: assert property (  // [R11]
      @(posedge core_clk) disable iff (!rst_n)
      deep_sleep |=> !busy && !conv_clk)
      else $error("converter active in deep sleep");

   a_idle_clock: assert property (  // [R2]
      @(posedge core_clk) disable iff (!rst_n)
      !busy |-> !conv_clk)
      else $error("converter clock runs while idle");

   a_ready_hold: assert property (  // [R7] [R13]
      @(posedge core_clk) disable iff (!rst_n)
      (|(result_ready & ~ready_clr)) |=>
      ((result_ready & $past(result_ready) & ~$past(ready_clr)) ==
       ($past(result_ready) & ~$past(ready_clr))))
      else $error("result flag dropped without clear");

   c_scan_pass:  cover property (@(posedge core_clk) scan_done);
   c_range_hit:  cover property (@(posedge core_clk) $rose(range_irq));
   c_fw_conv:    cover property (@(posedge core_clk)
                                 !scan_mode && cif.done);
   c_back2back:  cover property (@(posedge core_clk)
                                 cif.done ##1 sample_hold);

endmodule

// ===== hdl/sar_conv_timer.sv
// Converter timing engine: clock divider, sample window, conversion
module sar_conv_timer
   import sar_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   conv_if.timer    cif
);
`include "sar_seq_map.svh"

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      phase_e                 ph;   // Current phase
      logic [`SAR_DIV_W-1:0]  div;  // Core cycle within a converter clock
      logic [`SAR_CNT_W-1:0]  cnt;  // Converter clocks left in phase
      logic                   clk;  // Converter clock level
   } tim_s;

   localparam logic [`SAR_DIV_W-1:0] DIV_LAST =
      `SAR_DIV_W'(`SAR_CONV_DIV - 1);
   localparam logic [`SAR_CNT_W-1:0] CONV_LAST =
      `SAR_CNT_W'(`SAR_CONV_CLKS - 1);

   tim_s s;       // Registered state
   tim_s next_s;  // Next state
   logic tick;    // Last core cycle of a converter clock

   ////////////////////////////////////////////////////////////////////////
   // End of a converter clock, and the last core cycle of a conversion;
   // kept apart from the next-state logic so done never waits on start
   assign tick     = (s.div == DIV_LAST);
   assign cif.done = (s.ph == PH_CONVERT) && tick && (s.cnt == '0);

   // Next state: phases last whole converter clocks, divider restarts
   always_comb begin
      next_s   = s;
      // Divider runs only while busy, and realigns at each phase change
      next_s.div = (s.ph == PH_IDLE || tick) ? '0 : s.div + 1'b1;
      case (s.ph)
         PH_IDLE: begin
            // Window length is the channel's own setting plus one [R3]
            if (cif.start) begin
               next_s.ph  = PH_SAMPLE;
               next_s.cnt = `SAR_CNT_W'(cif.len);
            end
         end
         PH_SAMPLE: begin
            if (tick) begin
               if (s.cnt == '0) begin
                  next_s.ph  = PH_CONVERT;
                  next_s.cnt = CONV_LAST;  // Fixed conversion length [R2]
               end else begin
                  next_s.cnt = s.cnt - 1'b1;
               end
            end
         end
         PH_CONVERT: begin
            if (tick) begin
               if (s.cnt != '0) begin
                  next_s.cnt = s.cnt - 1'b1;
               end else if (cif.start) begin
                  // Next window opens with no gap [R5]
                  next_s.ph  = PH_SAMPLE;
                  next_s.cnt = `SAR_CNT_W'(cif.len);
               end else begin
                  next_s.ph = PH_IDLE;
               end
            end
         end
         default: begin
            next_s.ph = PH_IDLE;
         end
      endcase
      // Power-down stops everything, including the clock [R11]
      if (cif.halt) begin
         next_s.ph  = PH_IDLE;
         next_s.div = '0;
      end
      next_s.clk = (next_s.ph != PH_IDLE) && (next_s.div == '0);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s    <= '0;
         s.ph <= PH_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign cif.sampling   = (s.ph == PH_SAMPLE);
   assign cif.converting = (s.ph == PH_CONVERT);
   assign cif.conv_clk   = s.clk;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   localparam int CONV_CYC = `SAR_CONV_CLKS * `SAR_CONV_DIV;
   logic [11:0] samp_cyc;  // Cycles spent in the current window
   stime_t      samp_len;  // Setting the window was started with

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_cyc <= '0;
         samp_len <= '0;
      end else begin
         samp_cyc <= (s.ph == PH_SAMPLE) ? samp_cyc + 1'b1 : '0;
         if (next_s.ph == PH_SAMPLE && s.ph != PH_SAMPLE) begin
            samp_len <= cif.len;
         end
      end
   end

   a_conv_length: assert property (  // [R2]
      @(posedge core_clk) disable iff (!rst_n)
      cif.done |-> $past(cif.converting, CONV_CYC - 1) &&
                   !$past(cif.converting, CONV_CYC))
      else $error("conversion length wrong");

   a_sample_window: assert property (  // [R3] [R8]
      @(posedge core_clk) disable iff (!rst_n)
      (s.ph == PH_SAMPLE && next_s.ph == PH_CONVERT) |->
      int'(samp_cyc) == (int'(samp_len) + 1) * `SAR_CONV_DIV - 1)
      else $error("sample window length wrong");

   a_conv_clk_rate: assert property (  // [R2]
      @(posedge core_clk) disable iff (!rst_n)
      $rose(cif.conv_clk) |=> !cif.conv_clk [*2])
      else $error("converter clock too fast");

   a_sleep_halt: assert property (  // [R11]
      @(posedge core_clk) disable iff (!rst_n)
      cif.halt |=> (s.ph == PH_IDLE) && !cif.conv_clk)
      else $error("engine runs during power-down");

endmodule

// ===== hdl/sar_seq_map.svh
// Constants for the converter channel sequencer: widths and timing counts
`ifndef SAR_SEQ_MAP_SVH
`define SAR_SEQ_MAP_SVH

// Result width and channel count
`define SAR_DATA_W 12
`define SAR_CHANNELS 8
`define SAR_CHAN_W 3
// Per-channel sample time field width, in converter clocks
`define SAR_STIME_W 8
// Core clock rate and the highest converter clock rate, in Hz
`define SAR_FCORE_HZ 50000000
`define SAR_FCONV_MAX_HZ 18000000
// Core cycles per converter clock, rounded up so the limit holds
`define SAR_CONV_DIV \
   ((`SAR_FCORE_HZ + `SAR_FCONV_MAX_HZ - 1) / `SAR_FCONV_MAX_HZ)
`define SAR_DIV_W 2
// Converter clocks spent on each conversion
`define SAR_CONV_CLKS 18
`define SAR_CNT_W 9
// Reset values of the control state
`define SAR_RST_CHAN 3'h0
`define SAR_RST_FLAG 1'h0

`endif

// ===== hdl/sar_seq_pkg.sv
// Types shared by the converter channel sequencer modules
package sar_seq_pkg;
`include "sar_seq_map.svh"

   // Phase of the converter timing engine
   typedef enum logic [2:0] {
      PH_IDLE    = 3'b001,
      PH_SAMPLE  = 3'b010,
      PH_CONVERT = 3'b100
   } phase_e;

   typedef logic [`SAR_DATA_W-1:0] sample_t;   // One conversion result
   typedef logic [`SAR_CHAN_W-1:0] chan_t;     // Channel index
   typedef logic [`SAR_STIME_W-1:0] stime_t;   // Sample time setting

endpackage

// ===== testbench/analog_pins.sv
// Analog input pins seen by the converter through the channel multiplexer
module analog_pins
   import sar_seq_pkg::*;
(
   input  wire chan_t            mux_sel,
   input  wire logic [7:0][11:0] pin_level,
   output sample_t               sar_data_in
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // Selected pin drives the converter; the bench only moves the pin levels
   // while the engine is idle, so the level stands long before capture
   assign sar_data_in = pin_level[mux_sel];
endmodule

// ===== testbench/tb_sar_adc_channel_sequencer.sv
// Self-checking bench for the converter channel sequencer
module tb_sar_adc_channel_sequencer
   import sar_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic             core_clk;
   logic             rst_n;
   logic             deep_sleep;
   logic             scan_mode;
   logic             scan_run;
   logic [7:0]       chan_enable;
   logic             fw_start;
   chan_t            fw_chan;
   logic [7:0][7:0]  sample_time;
   sample_t          range_low;
   sample_t          range_high;
   logic             irq_clr;
   logic [7:0]       ready_clr;
   sample_t          sar_data_in;
   logic [7:0][11:0] pin_level;
   logic             conv_clk;
   chan_t            mux_sel;
   logic             sample_hold;
   logic             convert;
   logic             busy;
   logic [7:0][11:0] result;
   logic [7:0]       result_ready;
   logic             range_irq;
   logic             scan_done;

   // Expected outcome of one conversion
   typedef struct {
      chan_t   ch;
      sample_t val;
      int      sh;
      logic    irq;
      logic    nx;
   } note_s;

   note_s       q[$];           // Pending expectations
   note_s       nt;             // Note under comparison
   int          err_total = 0;  // Mismatches
   int          n_checks = 0;   // Comparisons
   int          done_cnt = 0;   // Scan pass pulses seen
   int          sh_cnt = 0;     // Sample window length
   int          cv_cnt = 0;     // Conversion length
   int          ck_cnt = 0;     // Converter clocks in conversion
   logic        pc = 1'b0;      // Converting on previous edge
   chan_t       ps;             // Channel on previous edge
   logic [31:0] seed = 32'he459;

   sar_adc_channel_sequencer i_dut (.core_clk, .rst_n, .deep_sleep,
      .scan_mode, .scan_run, .chan_enable, .fw_start, .fw_chan,
      .sample_time, .range_low, .range_high, .irq_clr, .ready_clr,
      .sar_data_in, .conv_clk, .mux_sel, .sample_hold, .convert, .busy,
      .result, .result_ready, .range_irq, .scan_done);

   analog_pins i_pins (.mux_sel, .pin_level, .sar_data_in);

   always #10 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////////
   // Xorshift source for pin levels and sample times
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Compare one value and count it
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // Print counts and verdict, then stop
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Bounded wait for the engine to go idle, then one more edge
   task automatic wait_idle();
      int n;
      n = 0;
      @(negedge core_clk);
      while (busy !== 1'b0 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 3000) begin
         chk("idle_timeout", 0, 1);
         wrap_up();
      end
      @(negedge core_clk);
   endtask

   // One firmware conversion, with a stray request while busy
   task automatic fw_conv(chan_t ch, logic [7:0] st, sample_t pin,
                          sample_t lo, sample_t hi, logic irq);
      @(negedge core_clk);
      pin_level[ch] = pin;
      sample_time[ch] = st;
      range_low = lo;
      range_high = hi;
      irq_clr = 1'b1;
      ready_clr = 8'hff;
      @(negedge core_clk);
      irq_clr = 1'b0;
      ready_clr = 8'h00;
      fw_start = 1'b1;
      fw_chan = ch;
      q.push_back('{ch, pin, (int'(st) + 1) * 3, irq, 1'b0});
      @(negedge core_clk);
      fw_chan = ch + 3'h1;   // Engine busy: must be dropped
      @(negedge core_clk);
      fw_start = 1'b0;
      wait_idle();
      chk("leftover", 0, q.size());
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Monitor: sees pre-edge values, checks each finished conversion
   always @(posedge core_clk) begin
      if (!rst_n || deep_sleep) begin
         sh_cnt = 0;
         cv_cnt = 0;
         ck_cnt = 0;
         pc = 1'b0;
      end else begin
         if (pc && !convert) begin
            if (q.size() == 0) begin
               chk("unexpected_result", 0, 1);
            end else begin
               nt = q.pop_front();
               chk("channel", nt.ch, ps);
               chk("result", nt.val, result[ps]);
               chk("ready", 1, result_ready[ps]);
               chk("window", nt.sh, sh_cnt);
               chk("conv_len", 54, cv_cnt);
               chk("conv_clks", 18, ck_cnt);
               chk("range_irq", nt.irq, range_irq);
               chk("no_gap", nt.nx, sample_hold);
            end
            sh_cnt = 0;
            cv_cnt = 0;
            ck_cnt = 0;
         end
         if (sample_hold) sh_cnt++;
         if (convert) cv_cnt++;
         if (convert && conv_clk) ck_cnt++;
         if (scan_done) done_cnt++;
         pc = convert;
         ps = mux_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] r;
      sample_t     pin;
      chan_t       c;
      int          n;
      core_clk = 1'b0;
      {rst_n, deep_sleep, scan_mode, scan_run, fw_start, irq_clr} = '0;
      {chan_enable, fw_chan, ready_clr, range_low} = '0;
      sample_time = '0;
      pin_level = '0;
      range_high = 12'hfff;
      repeat (20) @(negedge core_clk);
      chk("rst_busy", 0, busy);
      chk("rst_ready", 0, result_ready);
      chk("rst_irq", 0, range_irq);
      chk("rst_clk", 0, conv_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      // Every channel by firmware, limits on and just past each boundary
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         pin = 12'h100 + sample_t'(r[9:0]);
         c = chan_t'(i);
         case (i % 4)
            1: fw_conv(c, 8'(r[18:16]), pin, pin + 12'h001, 12'hfff, 1'b1);
            3: fw_conv(c, 8'(r[18:16]), pin, 12'h000, pin - 12'h001, 1'b1);
            default: fw_conv(c, 8'(r[18:16]), pin, pin, pin, 1'b0);
         endcase
      end
      $display("test firmware_select done");
      // Deep sleep in mid-conversion: abandoned, nothing restarts
      @(negedge core_clk);
      ready_clr = 8'hff;
      fw_start = 1'b1;
      fw_chan = 3'h0;
      @(negedge core_clk);
      ready_clr = 8'h00;
      fw_start = 1'b0;
      repeat (20) @(negedge core_clk);
      chk("sleep_busy_before", 1, busy);
      deep_sleep = 1'b1;
      fw_start = 1'b1;
      repeat (3) @(negedge core_clk);
      chk("sleep_busy", 0, busy);
      chk("sleep_clk", 0, conv_clk);
      chk("sleep_ready", 0, result_ready[0]);
      fw_start = 1'b0;
      deep_sleep = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("wake_busy", 0, busy);
      $display("test deep_sleep done");
      // Hardware scan of channels 2, 5, 7 for two passes
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         pin_level[i] = 12'h100 + 12'(r[9:0]);
         sample_time[i] = 8'(r[18:16]);
      end
      pin_level[5] = 12'hf80;
      range_low = 12'h080;
      range_high = 12'hf00;
      irq_clr = 1'b1;
      ready_clr = 8'hff;
      @(negedge core_clk);
      irq_clr = 1'b0;
      ready_clr = 8'h00;
      for (int k = 0; k < 6; k++) begin
         c = (k % 3 == 0) ? 3'h2 : (k % 3 == 1) ? 3'h5 : 3'h7;
         q.push_back('{c, pin_level[c], (int'(sample_time[c]) + 1) * 3,
                       k > 0, k < 5});
      end
      done_cnt = 0;
      scan_mode = 1'b1;
      chan_enable = 8'ha4;
      scan_run = 1'b1;
      n = 0;
      while (q.size() > 1 && n < 5000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 5000) begin
         chk("scan_timeout", 0, 1);
         wrap_up();
      end
      scan_run = 1'b0;
      wait_idle();
      chk("scan_passes", 1, done_cnt);
      chk("leftover", 0, q.size());
      $display("test hardware_scan done");
      wrap_up();
   end
endmodule
